/* File: rtl/wfd_top.sv */
// wakeup frame detector: apb registers, filter storage, per-filter crc matching
//
// Contract
// - setting wake_detect_enable starts comparing received frames to the filters
// - while detection is on, frames are not passed on the normal receive path
// - a match sets wake_frame_seen, restores full power and pulses remote wakeup
// - filter count is a build parameter of 4 or 8, giving 20 or 40 words
// - the same count of consecutive port reads returns the whole storage
// - a wakeup frame must pass address filtering and match an enabled filter crc
// - each filter has its own byte mask and pattern offset
// - the offset gives the frame position of the first checkable byte
// - mask bit j includes frame byte offset plus j in the crc check
// - each mask spans four words, word k holding bits 32k+31 down to 32k
// - mask word lsb maps to the earliest byte on the wire
// - after masks come command, offset, then crc words, lower filter in low half
// - filter 0 command sits in the lowest byte lane, others ascending
// - eight filters use two command, two offset and four crc words
`timescale 1ns/1ns
`include "wfd_cfg.svh"

module wfd_top #(
  parameter int NUM_FILTERS = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic pready_o,
  output logic [31:0] prdata_o,
  output logic pslverr_o,
  // receive stream from the mac, address filter verdict valid with eof
  input wire wfd_pkg::wfd_rx_t rx_i,
  input wire logic rx_addr_pass_i,
  // normal receive path
  output wfd_pkg::wfd_rx_t rx_o,
  // power and wakeup
  output logic wake_detect_enable_o,
  output logic wake_frame_seen_o,
  output logic full_power_o,
  output logic remote_wakeup_o
);

  // =====================================================================
  // layout of the filter storage
  localparam int NF = NUM_FILTERS;
  localparam logic [`WFD_PTR_W-1:0] CMD_BASE = `WFD_PTR_W'(`WFD_MASK_WORDS * NF);
  localparam logic [`WFD_PTR_W-1:0] OFF_BASE = `WFD_PTR_W'(`WFD_MASK_WORDS * NF + NF / `WFD_LANES);
  localparam logic [`WFD_PTR_W-1:0] CRC_BASE = `WFD_PTR_W'(`WFD_MASK_WORDS * NF + 2 * (NF / `WFD_LANES));
  localparam logic [`WFD_PTR_W-1:0] LAST_WORD = `WFD_PTR_W'(5 * NF - 1);

  // =====================================================================
  // storage, flip-flops indexed by filter
  logic [`WFD_MASK_W-1:0] mask_q [NF];
  logic [`WFD_CMD_W-1:0] cmd_q [NF];
  logic [`WFD_OFFSET_W-1:0] offset_q [NF];
  logic [`WFD_CRC_W-1:0] crc_ref_q [NF];

  logic [`WFD_PTR_W-1:0] ptr;
  wfd_pkg::wfd_bus_st_t bus_st;
  logic done;
  logic commit;
  logic hit_ctrl;
  logic hit_port;
  logic port_wr;
  logic port_acc;
  logic ctrl_wr;

  // =====================================================================
  // read assembly of one storage word, laid out exactly as writes use it
  function automatic logic [31:0] port_word(input logic [`WFD_PTR_W-1:0] w);
    logic [31:0] r;
    r = `WFD_RST_WORD;
    for (int i = 0; i < NF; i++) begin
      for (int j = 0; j < `WFD_MASK_WORDS; j++) begin
        if (w == `WFD_PTR_W'(`WFD_MASK_WORDS * i + j)) begin
          r = mask_q[i][32*j +: 32];
        end
      end
      if (w == CMD_BASE + `WFD_PTR_W'(i / `WFD_LANES)) begin
        r[`WFD_LANE_W*(i % `WFD_LANES) +: `WFD_CMD_W] = cmd_q[i];
      end
      if (w == OFF_BASE + `WFD_PTR_W'(i / `WFD_LANES)) begin
        r[`WFD_LANE_W*(i % `WFD_LANES) +: `WFD_OFFSET_W] = offset_q[i];
      end
      if (w == CRC_BASE + `WFD_PTR_W'(i / `WFD_CRC_PER_WORD)) begin
        r[`WFD_CRC_W*(i % `WFD_CRC_PER_WORD) +: `WFD_CRC_W] = crc_ref_q[i];
      end
    end
    return r;
  endfunction : port_word

  // =====================================================================
  // apb slave: two wait states so every answer comes from a flip-flop;
  // writes and pointer steps land only at the edge that completes the transfer
  assign hit_ctrl = (paddr_i == `WFD_OFF_CTRL);
  assign hit_port = (paddr_i == `WFD_OFF_PORT);
  assign done = (bus_st == wfd_pkg::WFD_ACCESS);
  assign commit = (bus_st == wfd_pkg::WFD_DONE) && psel_i && penable_i;
  assign port_acc = commit && hit_port;
  assign port_wr = port_acc && pwrite_i;
  assign ctrl_wr = commit && hit_ctrl && pwrite_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_st <= wfd_pkg::WFD_IDLE;
    end else begin
      unique case (bus_st)
        wfd_pkg::WFD_IDLE: begin
          if (psel_i && penable_i) begin
            bus_st <= wfd_pkg::WFD_ACCESS;
          end
        end
        wfd_pkg::WFD_ACCESS: begin
          bus_st <= wfd_pkg::WFD_DONE;
        end
        wfd_pkg::WFD_DONE: begin
          bus_st <= wfd_pkg::WFD_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= `WFD_RST_WORD;
    end else begin
      pready_o <= done;
      pslverr_o <= done && !hit_ctrl && !hit_port;
      prdata_o <= `WFD_RST_WORD;
      if (done && !pwrite_i && hit_ctrl) begin
        prdata_o[`WFD_BIT_EN] <= wake_detect_enable_o;
        prdata_o[`WFD_BIT_SEEN] <= wake_frame_seen_o;
      end else if (done && !pwrite_i && hit_port) begin
        prdata_o <= port_word(ptr);
      end
    end
  end

  // =====================================================================
  // word pointer through the filter storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ptr <= `WFD_RST_PTR;
    end else if (port_acc) begin
      ptr <= (ptr == LAST_WORD) ? `WFD_RST_PTR : ptr + `WFD_PTR_W'(1);
    end
  end

  // =====================================================================
  // storage writes
  generate
    for (genvar i = 0; i < NF; i++) begin : g_store
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          mask_q[i] <= '0;
          cmd_q[i] <= '0;
          offset_q[i] <= '0;
          crc_ref_q[i] <= '0;
        end else if (port_wr) begin
          for (int j = 0; j < `WFD_MASK_WORDS; j++) begin
            if (ptr == `WFD_PTR_W'(`WFD_MASK_WORDS * i + j)) begin
              mask_q[i][32*j +: 32] <= pwdata_i;
            end
          end
          if (ptr == CMD_BASE + `WFD_PTR_W'(i / `WFD_LANES)) begin
            cmd_q[i] <= pwdata_i[`WFD_LANE_W*(i % `WFD_LANES) +: `WFD_CMD_W];
          end
          if (ptr == OFF_BASE + `WFD_PTR_W'(i / `WFD_LANES)) begin
            offset_q[i] <= pwdata_i[`WFD_LANE_W*(i % `WFD_LANES) +: `WFD_OFFSET_W];
          end
          if (ptr == CRC_BASE + `WFD_PTR_W'(i / `WFD_CRC_PER_WORD)) begin
            crc_ref_q[i] <= pwdata_i[`WFD_CRC_W*(i % `WFD_CRC_PER_WORD) +: `WFD_CRC_W];
          end
        end
      end
    end
  endgenerate

  // =====================================================================
  // byte position within the current frame
  logic [`WFD_POS_W-1:0] pos;
  logic [`WFD_POS_W-1:0] byte_pos;
  logic check_q;
  logic addr_ok_q;
  logic [NF-1:0] hit;

  // first byte of a frame is position zero even though the counter still holds the old value
  assign byte_pos = rx_i.sof ? `WFD_RST_POS : pos;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos <= `WFD_RST_POS;
    end else if (rx_i.valid) begin
      pos <= (&byte_pos) ? byte_pos : byte_pos + `WFD_POS_W'(1);
    end
  end

  // =====================================================================
  // per-filter selection and crc
  generate
    for (genvar i = 0; i < NF; i++) begin : g_filt
      logic [`WFD_POS_W-1:0] rel;
      logic in_win;
      logic take;
      logic [`WFD_CRC_W-1:0] crc_now;

      assign rel = byte_pos - `WFD_POS_W'(offset_q[i]);
      assign in_win = (byte_pos >= `WFD_POS_W'(offset_q[i])) && (rel < `WFD_POS_W'(`WFD_MASK_W));
      // mask bit 0 of word 0 is the byte met first on the wire
      assign take = rx_i.valid && in_win && mask_q[i][rel[6:0]];

      wfd_crc16 u_crc (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(rx_i.valid && rx_i.sof),
        .en_i(take),
        .data_i(rx_i.data),
        .crc_o(crc_now)
      );

      assign hit[i] = cmd_q[i][`WFD_CMD_EN_BIT] && (crc_now == crc_ref_q[i]);
    end
  endgenerate

  // =====================================================================
  // verdict one cycle after the last byte, once every crc has absorbed it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      check_q <= 1'b0;
      addr_ok_q <= 1'b0;
    end else begin
      check_q <= rx_i.valid && rx_i.eof && wake_detect_enable_o;
      addr_ok_q <= rx_addr_pass_i;
    end
  end

  logic wake_match;
  assign wake_match = check_q && addr_ok_q && (|hit);

  // =====================================================================
  // wake control/status register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_detect_enable_o <= 1'b0;
    end else if (ctrl_wr) begin
      wake_detect_enable_o <= pwdata_i[`WFD_BIT_EN];
    end
  end

  // write one clears; a match in the same cycle wins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_frame_seen_o <= 1'b0;
    end else begin
      wake_frame_seen_o <= (wake_frame_seen_o && !(ctrl_wr && pwdata_i[`WFD_BIT_SEEN])) || wake_match;
    end
  end

  // =====================================================================
  // power state and remote wakeup
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      full_power_o <= 1'b1;
      remote_wakeup_o <= 1'b0;
    end else begin
      remote_wakeup_o <= wake_match;
      if (wake_match) begin
        full_power_o <= 1'b1;
      end else if (ctrl_wr && pwdata_i[`WFD_BIT_EN] && !wake_detect_enable_o) begin
        full_power_o <= 1'b0;
      end
    end
  end

  // =====================================================================
  // normal receive path, blocked while detecting
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_o <= '0;
    end else if (wake_detect_enable_o) begin
      rx_o <= '0;
    end else begin
      rx_o <= rx_i;
    end
  end

endmodule : wfd_top

/* File: rtl/wfd_cfg.svh */
// address map, field positions, reset values and crc constants of the wakeup frame detector
`ifndef WFD_CFG_SVH
`define WFD_CFG_SVH

// =====================================================================
// register map
`define WFD_OFF_CTRL 12'h000
`define WFD_OFF_PORT 12'h004
`define WFD_ADDR_W 12

// =====================================================================
// wake control/status fields
`define WFD_BIT_EN 0
`define WFD_BIT_SEEN 1

// =====================================================================
// filter storage layout
`define WFD_MASK_W 128
`define WFD_MASK_WORDS 4
`define WFD_CMD_W 4
`define WFD_CMD_EN_BIT 0
`define WFD_OFFSET_W 8
`define WFD_LANE_W 8
`define WFD_LANES 4
`define WFD_CRC_W 16
`define WFD_CRC_PER_WORD 2
`define WFD_PTR_W 6
`define WFD_POS_W 12

// =====================================================================
// crc-16, reflected, lsb of each byte first as on the wire
`define WFD_CRC_INIT 16'hFFFF
`define WFD_CRC_POLY 16'hA001

// =====================================================================
// reset values
`define WFD_RST_WORD 32'h0000_0000
`define WFD_RST_PTR 6'h00
`define WFD_RST_POS 12'h000

`endif

/* File: rtl/wfd_pkg.sv */
// types shared by the wakeup frame detector
package wfd_pkg;

  // =====================================================================
  // receive byte stream
  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic [7:0] data;
  } wfd_rx_t;

  // =====================================================================
  // apb request
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } wfd_apb_req_t;

  // =====================================================================
  // bus slave phases
  typedef enum logic [1:0] {
    WFD_IDLE,
    WFD_ACCESS,
    WFD_DONE
  } wfd_bus_st_t;

endpackage : wfd_pkg

/* File: rtl/wfd_crc16.sv */
// byte-wide crc-16 accumulator for one wakeup filter
`timescale 1ns/1ns
`include "wfd_cfg.svh"

module wfd_crc16 (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic clear_i,
  input wire logic en_i,
  input wire logic [7:0] data_i,
  // result
  output logic [`WFD_CRC_W-1:0] crc_o
);

  logic [`WFD_CRC_W-1:0] next_crc;

  // a selected first byte of a frame steps from the seed, not from the previous frame
  always_comb begin
    next_crc = clear_i ? `WFD_CRC_INIT : crc_o;
    for (int b = 0; b < 8; b++) begin
      if (next_crc[0] ^ data_i[b]) begin
        next_crc = (next_crc >> 1) ^ `WFD_CRC_POLY;
      end else begin
        next_crc = next_crc >> 1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crc_o <= `WFD_CRC_INIT;
    end else if (en_i) begin
      crc_o <= next_crc;
    end else if (clear_i) begin
      crc_o <= `WFD_CRC_INIT;
    end
  end

endmodule : wfd_crc16

/* File: test/wfd_top_assertions.sv */
// concurrent port checks for the wakeup frame detector
`timescale 1ns/1ns

module wfd_top_checker #(
  parameter int NUM_FILTERS = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pready_o,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  input wire wfd_pkg::wfd_rx_t rx_i,
  input wire logic rx_addr_pass_i,
  input wire wfd_pkg::wfd_rx_t rx_o,
  input wire logic wake_detect_enable_o,
  input wire logic wake_frame_seen_o,
  input wire logic full_power_o,
  input wire logic remote_wakeup_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ready_single: assert property (pready_o |=> !pready_o) else $error("pready longer than one cycle");
  a_ready_delay: assert property ($rose(psel_i && penable_i) |-> ##2 pready_o) else $error("late pready");
  a_err_ready: assert property (pslverr_o |-> pready_o) else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000) else $error("stale read data");
  a_rx_blocked: assert property (wake_detect_enable_o |-> rx_o == '0) else $error("frame passed in wake mode");
  a_rx_copy: assert property (!wake_detect_enable_o && !$past(wake_detect_enable_o) && !$past(rst_i)
    |-> rx_o == $past(rx_i)) else $error("receive copy wrong");
  a_wake_eof: assert property (remote_wakeup_o
    |-> $past(rx_i.valid && rx_i.eof && rx_addr_pass_i && wake_detect_enable_o, 2))
    else $error("wakeup without qualified frame end");
  a_wake_flags: assert property ($rose(remote_wakeup_o) |-> wake_frame_seen_o && full_power_o)
    else $error("wakeup without seen or power");
  a_wake_pulse: assert property (remote_wakeup_o |=> !remote_wakeup_o) else $error("wakeup pulse too long");
  a_seen_cause: assert property ($rose(wake_frame_seen_o) |-> remote_wakeup_o) else $error("seen without wakeup");
  a_power_drop: assert property ($fell(full_power_o) |-> wake_detect_enable_o) else $error("power drop outside wake");

  c_wake: cover property (remote_wakeup_o);
  c_err: cover property (pslverr_o);
  c_read: cover property (pready_o && prdata_o != 32'h0000_0000);
endmodule : wfd_top_checker

bind wfd_top wfd_top_checker #(.NUM_FILTERS(NUM_FILTERS)) chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
  .rx_i(rx_i), .rx_addr_pass_i(rx_addr_pass_i), .rx_o(rx_o), .wake_detect_enable_o(wake_detect_enable_o),
  .wake_frame_seen_o(wake_frame_seen_o), .full_power_o(full_power_o), .remote_wakeup_o(remote_wakeup_o));

/* File: test/wfd_rx_src.sv */
// receive stream source standing in for the mac receive path
`timescale 1ns/1ns

module wfd_rx_src (
  // clock
  input wire logic clk_i,
  // stream toward the detector
  output wfd_pkg::wfd_rx_t rx_o,
  output logic addr_pass_o
);
  initial begin
    rx_o = '0;
    addr_pass_o = 1'b0;
  end

  // sof on the first byte, eof and address verdict on the last
  task automatic send(input logic [7:0] bytes[$], input logic pass);
    int n;
    n = bytes.size();
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      rx_o <= {1'b1, i == 0, i == n - 1, bytes[i]};
      addr_pass_o <= (i == n - 1) ? pass : ~pass;
    end
    @(posedge clk_i);
    // idle lines flip so that no stale byte can pass for a valid one
    rx_o <= {3'b000, ~bytes[n-1]};
    addr_pass_o <= ~pass;
  endtask : send
endmodule : wfd_rx_src

/* File: test/wfd_top_bench.sv */
// self-checking bench for the wakeup frame detector
`timescale 1ns/1ns
`include "wfd_cfg.svh"

module wfd_top_bench;
  localparam int NF = 4;
  localparam int WORDS = 5 * NF;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic pready, pslverr, wake_en, seen, full_power, wakeup, addr_pass, err;
  logic [31:0] prdata, rdat;
  wfd_pkg::wfd_rx_t rx_in, rx_out;
  logic [31:0] image [WORDS];
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int rx_beats = 0;

  always #25 clk_i = ~clk_i;

  // bytes delivered on the normal receive path
  always @(posedge clk_i) begin
    if (rx_out.valid === 1'b1) rx_beats++;
  end

  wfd_top #(.NUM_FILTERS(NF)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
    .pslverr_o(pslverr), .rx_i(rx_in), .rx_addr_pass_i(addr_pass), .rx_o(rx_out),
    .wake_detect_enable_o(wake_en), .wake_frame_seen_o(seen), .full_power_o(full_power),
    .remote_wakeup_o(wakeup));
  wfd_rx_src src_u (.clk_i(clk_i), .rx_o(rx_in), .addr_pass_o(addr_pass));

  // =====================================================================
  // helpers
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      num_errors++;
    end
  endtask : check

  // waits for pready with no assumed latency; only the timeout ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [15:0] crc16(input logic [15:0] bits);
    logic [15:0] c;
    c = `WFD_CRC_INIT;
    for (int i = 0; i < 16; i++) c = (c[0] ^ bits[i]) ? (c >> 1) ^ `WFD_CRC_POLY : c >> 1;
    return c;
  endfunction : crc16

  task automatic wakes(input string what, input logic [7:0] f[$], input logic pass, input int exp, input int beats);
    int hits;
    int beats0;
    hits = 0;
    beats0 = rx_beats;
    src_u.send(f, pass);
    repeat (4) begin
      @(posedge clk_i);
      if (wakeup === 1'b1) hits++;
    end
    check(what, exp, hits);
    check({what, " rx beats"}, beats, rx_beats - beats0);
  endtask : wakes

  // =====================================================================
  // scenarios
  task automatic reset_values;
    apb(1'b0, `WFD_OFF_CTRL, 32'h0000_0000);
    check("ctrl reset", 32'h0000_0000, rdat);
    check("power reset", 32'h0000_0001, full_power);
  endtask : reset_values

  task automatic load_storage;
    for (int i = 0; i < WORDS; i++) image[i] = 32'hA5A5_0000 | i;
    image[0] = 32'h0000_0003;
    image[16] = 32'h0000_0001;
    image[17] = 32'h0000_0001;
    image[18] = {16'h1234, crc16({8'h3C, 8'hA5})};
    image[19] = 32'hABCD_5678;
    for (int i = 0; i < WORDS; i++) apb(1'b1, `WFD_OFF_PORT, image[i]);
    for (int i = 0; i < WORDS; i++) begin
      apb(1'b0, `WFD_OFF_PORT, 32'h0000_0000);
      check("storage word", image[i], rdat);
    end
  endtask : load_storage

  task automatic unmapped;
    apb(1'b0, 12'h008, 32'h0000_0000);
    check("unmapped err", 32'h0000_0001, err);
    check("unmapped data", 32'h0000_0000, rdat);
  endtask : unmapped

  task automatic wake_match;
    apb(1'b1, `WFD_OFF_CTRL, 32'h0000_0001);
    // the write lands at the completing edge, so its effect shows one edge later
    @(posedge clk_i);
    check("power in wake mode", 32'h0000_0000, full_power);
    check("enable pin", 32'h0000_0001, wake_en);
    wakes("wake no address", '{8'h77, 8'hA5, 8'h3C, 8'h00}, 1'b0, 0, 0);
    wakes("wake bad byte", '{8'h77, 8'hA5, 8'h3D, 8'h00}, 1'b1, 0, 0);
    wakes("wake match", '{8'h11, 8'hA5, 8'h3C, 8'h5A}, 1'b1, 1, 0);
    check("power after wake", 32'h0000_0001, full_power);
    check("seen pin", 32'h0000_0001, seen);
    apb(1'b0, `WFD_OFF_CTRL, 32'h0000_0000);
    check("ctrl after wake", 32'h0000_0003, rdat);
    apb(1'b1, `WFD_OFF_CTRL, 32'h0000_0003);
    apb(1'b0, `WFD_OFF_CTRL, 32'h0000_0000);
    check("seen cleared", 32'h0000_0001, rdat);
    apb(1'b1, `WFD_OFF_CTRL, 32'h0000_0000);
    wakes("wake when off", '{8'h11, 8'hA5, 8'h3C, 8'h5A}, 1'b1, 0, 4);
  endtask : wake_match

  // =====================================================================
  // run control
  task automatic close_out;
    $display("checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    reset_values();
    load_storage();
    unmapped();
    wake_match();
    close_out();
  end
endmodule : wfd_top_bench
